// ===== rtl/hfp_host.sv
// Host controller for an asynchronous boot-block flash: AHB-Lite register slave
// plus a pin engine that drives chip select, output and write strobes.
// Assumes a single AHB-Lite master, flash pins wired directly to the ports.
//
// Operation
// RULE_01: Array has boot, parameter and main blocks
// RULE_02: Boot block sits at top or bottom
// RULE_03: Erase clears block; program changes one location
// RULE_04: Internal sequencer runs program and erase timing
// RULE_05: Device keeps readable busy and result flags
// RULE_06: Low program supply refuses program and erase
// RULE_07: High voltage on reset pin unlocks boot
// RULE_08: Chip select and reset high give standby
// RULE_09: Reset low blocks writes, floats outputs
// RULE_10: Host waits recovery and wake after reset
// RULE_11: Device returns to read array after reset
// RULE_12: System reset drives the flash reset pin
// RULE_13: Address pins latched during each write cycle
// RULE_14: Host holds address and data through rising
// RULE_15: Commands written with chip select and write
// RULE_16: Data drivers on only during enabled reads
// RULE_17: Chip select high deselects the device
// RULE_18: Width chosen at power-up, upper pin addresses
// RULE_19: High voltage on signature pin selects identifiers
// RULE_20: Byte signature mode returns lower byte only
// RULE_21: Locked boot block rejects, sets failure flag
// RULE_22: Byte mode floats data lines eight-fourteen
// RULE_23: Locked boot still readable, others writable
// RULE_24: Read array mode drives array data out
`include "hfp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hfp_host (
  input  wire logic               i_sys_clk,
  input  wire logic               i_resetn,
  // AHB-Lite slave
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  output logic [31:0]             o_hrdata,
  // Flash pins
  output logic                    o_ce_n,
  output logic                    o_oe_n,
  output logic                    o_we_n,
  output logic                    o_rp_n,
  output logic                    o_rp_hv,
  output logic                    o_wp_n,
  output logic                    o_byte_n,
  output logic                    o_a9_hv,
  output hfp_pkg::hfp_addr_t      o_addr,
  output hfp_pkg::hfp_data_t      o_dq_o,
  output hfp_pkg::hfp_data_t      o_dq_oe,
  input  wire hfp_pkg::hfp_data_t i_dq_i
);
  import hfp_pkg::*;

  // Bus phase capture
  logic        wr_pend_q;      // Write data phase pending
  logic [7:0]  wr_ofs_q;       // Offset of pending write
  // Software registers
  logic [`HFP_CTRL_W-1:0] ctrl_q;   // Control bits
  logic [19:0] addr_q;         // Flash byte/word address, bit 0 is low address in byte mode
  hfp_data_t   wdata_q;        // Data for the next write cycle
  hfp_data_t   rdata_q;        // Data of the last read cycle
  logic        refused_q;      // Sticky: a command came while not allowed
  // Recovery tracking
  hfp_count_t  rec_cnt_q;      // Cycles since the reset pin rose
  logic        out_ok;         // Reads allowed
  logic        wake_ok;        // Writes allowed
  // Pin engine
  hfp_state_e  state_q;        // Engine state
  logic        tmr_load;       // Start a phase
  hfp_count_t  tmr_val;        // Phase length minus one
  logic        tmr_done;       // Phase finished
  hfp_data_t   dq_sync;        // Synchronised data pins
  logic        go_rd;          // Accepted read command
  logic        go_wr;          // Accepted write command
  logic        cmd_wr;         // Command register written
  logic        byte_mode;      // Width currently on the pins

  // Register read mux, shared by the bus read path
  function automatic logic [31:0] reg_read(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (ofs == `HFP_CTRL_OFS) begin
      v[`HFP_CTRL_W-1:0] = ctrl_q;
    end else if (ofs == `HFP_ADDR_OFS) begin
      v[19:0] = addr_q;
    end else if (ofs == `HFP_WDATA_OFS) begin
      v[15:0] = wdata_q;
    end else if (ofs == `HFP_STATUS_OFS) begin
      v[`HFP_ST_BUSY]    = (state_q != ST_IDLE);
      v[`HFP_ST_OUT_OK]  = out_ok;
      v[`HFP_ST_WAKE_OK] = wake_ok;
      v[`HFP_ST_REFUSED] = refused_q;
    end else if (ofs == `HFP_RDATA_OFS) begin
      v[15:0] = rdata_q;
    end
    return v;
  endfunction

  // Zero-wait slave, always OKAY; unmapped reads give zero
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // Address phase capture and registered read data
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      o_hrdata  <= 32'h0000_0000;
    end else if (i_hready) begin
      wr_pend_q <= i_hsel && i_htrans[1] && i_hwrite;
      wr_ofs_q  <= i_haddr[7:0];
      if (i_hsel && i_htrans[1] && !i_hwrite) begin
        o_hrdata <= reg_read(i_haddr[7:0]);
      end
    end
  end

  assign cmd_wr = wr_pend_q && (wr_ofs_q == `HFP_CMD_OFS);
  // Reads need valid outputs, writes need the wake time as well
  assign go_rd  = cmd_wr && i_hwdata[`HFP_CMD_READ] && (state_q == ST_IDLE) && out_ok; // [RULE_10]
  assign go_wr  = cmd_wr && i_hwdata[`HFP_CMD_WRITE] && !i_hwdata[`HFP_CMD_READ]
                  && (state_q == ST_IDLE) && wake_ok; // [RULE_10]

  // Software register writes; address and data frozen while a cycle runs
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ctrl_q  <= `HFP_CTRL_RST;
      addr_q  <= 20'h00000;
      wdata_q <= 16'h0000;
    end else if (wr_pend_q) begin
      if (wr_ofs_q == `HFP_CTRL_OFS) begin
        ctrl_q <= i_hwdata[`HFP_CTRL_W-1:0];
      end else if (wr_ofs_q == `HFP_ADDR_OFS && state_q == ST_IDLE) begin
        addr_q <= i_hwdata[19:0];
      end else if (wr_ofs_q == `HFP_WDATA_OFS && state_q == ST_IDLE) begin
        wdata_q <= i_hwdata[15:0];
      end
    end
  end

  // Refused flag: a new refusal wins over the clear by an accepted command
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      refused_q <= 1'b0;
    end else if (cmd_wr && (i_hwdata[1:0] != 2'b00) && !go_rd && !go_wr) begin
      refused_q <= 1'b1;
    end else if (go_rd || go_wr) begin
      refused_q <= 1'b0;
    end
  end

  // Reset pin follows system reset and the power-down bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_rp_n <= 1'b0; // [RULE_12]
    end else begin
      o_rp_n <= !ctrl_q[`HFP_CTRL_PDOWN]; // [RULE_12]
    end
  end

  // Static control pins; width may change only while the reset pin is low
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_rp_hv  <= 1'b0;
      o_wp_n   <= 1'b0;
      o_a9_hv  <= 1'b0;
      o_byte_n <= 1'b1;
    end else begin
      o_rp_hv <= ctrl_q[`HFP_CTRL_RP_HV] && !ctrl_q[`HFP_CTRL_PDOWN];
      o_wp_n  <= ctrl_q[`HFP_CTRL_WP_HIGH];
      o_a9_hv <= ctrl_q[`HFP_CTRL_SIG_HV];
      // Only while power-down is still asked for, so the width pin never moves
      // on the same edge at which the reset pin rises
      if (!o_rp_n && ctrl_q[`HFP_CTRL_PDOWN]) begin
        o_byte_n <= !ctrl_q[`HFP_CTRL_BYTE]; // [RULE_18]
      end
    end
  end

  assign byte_mode = !o_byte_n;

  // Count from the rising reset pin, saturating
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || !o_rp_n) begin
      rec_cnt_q <= 16'h0000;
    end else if (rec_cnt_q != 16'hFFFF) begin
      rec_cnt_q <= rec_cnt_q + 16'h0001;
    end
  end

  assign out_ok  = o_rp_n && (rec_cnt_q >= 16'(`HFP_RECOVERY_CYC)); // [RULE_10]
  assign wake_ok = o_rp_n && (rec_cnt_q >= 16'(`HFP_WAKE_CYC)) && out_ok; // [RULE_10]

  // Phase timer loads on each transition into a timed state
  always_comb begin
    tmr_load = 1'b0;
    tmr_val  = 16'h0000;
    case (state_q)
      ST_IDLE: begin
        if (go_rd) begin
          tmr_load = 1'b1;
          tmr_val  = 16'(`HFP_ACCESS_CYC - 1);
        end else if (go_wr) begin
          tmr_load = 1'b1;
          tmr_val  = 16'(`HFP_SETUP_CYC - 1);
        end
      end
      ST_WR_SETUP: begin
        tmr_load = tmr_done;
        tmr_val  = 16'(`HFP_WE_LOW_CYC - 1);
      end
      ST_WR_PULSE: begin
        tmr_load = tmr_done;
        tmr_val  = 16'(`HFP_HOLD_CYC - 1);
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  hfp_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_load    (tmr_load),
    .i_value   (tmr_val),
    .o_done    (tmr_done)
  );

  // Data pins pass two flops before the engine samples them
  hfp_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_dq_i),
    .o_sync    (dq_sync)
  );

  // Pin engine: strobes, address and data all from flops.
  // A read holds the output enable low long enough to cover the access time
  // plus the two synchroniser stages, trading speed for a safe sample.
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || !o_rp_n) begin
      state_q <= ST_IDLE;
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
      o_addr  <= 19'h00000;
      o_dq_o  <= 16'h0000;
      o_dq_oe <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // Word mode uses the low address bits, byte mode shifts up one
          o_addr <= byte_mode ? addr_q[19:1] : addr_q[18:0];
          if (go_rd) begin
            o_ce_n  <= 1'b0;
            o_oe_n  <= 1'b0;
            // Upper data pin carries the low address in byte mode
            o_dq_o  <= {addr_q[0], 15'h0000}; // [RULE_18]
            o_dq_oe <= {byte_mode, 15'h0000}; // [RULE_18]
            state_q <= ST_RD_WAIT;
          end else if (go_wr) begin
            o_ce_n  <= 1'b0;
            o_dq_o  <= byte_mode ? {addr_q[0], 7'h00, wdata_q[7:0]} : wdata_q;
            o_dq_oe <= byte_mode ? 16'h80FF : 16'hFFFF;
            state_q <= ST_WR_SETUP;
          end
        end
        ST_RD_WAIT: begin
          if (tmr_done) begin
            o_ce_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            o_dq_oe <= 16'h0000;
            state_q <= ST_IDLE;
          end
        end
        ST_WR_SETUP: begin
          if (tmr_done) begin
            o_we_n  <= 1'b0; // [RULE_15]
            state_q <= ST_WR_PULSE;
          end
        end
        ST_WR_PULSE: begin
          // Address and data stay put through the rising edge
          if (tmr_done) begin
            o_we_n  <= 1'b1; // [RULE_14]
            state_q <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          if (tmr_done) begin
            o_ce_n  <= 1'b1;
            o_dq_oe <= 16'h0000;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture read data; byte mode keeps only the low lane
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rdata_q <= 16'h0000;
    end else if (state_q == ST_RD_WAIT && tmr_done) begin
      rdata_q <= byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync; // [RULE_18]
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_write_wake: assert property ($fell(o_we_n) |-> wake_ok)  // [RULE_10]
    else $error("write strobe before wake time");
  a_read_recov: assert property ($fell(o_oe_n) |-> out_ok)  // [RULE_10]
    else $error("read before reset recovery");
  a_reset_follow: assert property (@(posedge i_sys_clk) disable iff (1'b0)  // [RULE_12]
                                   !i_resetn |=> !o_rp_n)
    else $error("reset pin not low after system reset");
  a_we_hold: assert property ($rose(o_we_n) |-> $stable(o_addr) && $stable(o_dq_o)
                              && (o_dq_oe[7:0] == 8'hFF) && !o_ce_n)  // [RULE_14]
    else $error("address or data moved at write edge");
  a_we_width: assert property ($fell(o_we_n) |-> (!o_we_n)[*5] ##1 o_we_n)  // [RULE_14]
    else $error("write pulse not five cycles");
  a_we_in_cs: assert property (!o_we_n |-> !o_ce_n && o_oe_n)  // [RULE_15]
    else $error("write strobe outside chip select");
  a_width_stable: assert property (o_rp_n && $past(o_rp_n) |-> $stable(o_byte_n))  // [RULE_18]
    else $error("width changed while out of reset");
  a_read_len: assert property ($fell(o_oe_n) |-> (!o_oe_n)[*8] ##1 (!o_oe_n)[*4] ##1 o_oe_n)  // [RULE_10]
    else $error("read strobe length wrong");

  c_read_done:  cover property ($rose(o_oe_n) && o_rp_n);
  c_write_done: cover property ($rose(o_we_n));
  c_refused:    cover property ($rose(refused_q));
  c_byte_read:  cover property ($fell(o_oe_n) && byte_mode);
endmodule // hfp_host
`default_nettype wire

// ===== rtl/hfp_defines.svh
// Constants for the boot-block flash host port: register offsets, field positions,
// reset values and strobe timing counts.
// Assumes a 100 MHz system clock; include by bare name.
`ifndef HFP_DEFINES_SVH
`define HFP_DEFINES_SVH

// Register byte offsets, one aligned word each
`define HFP_CTRL_OFS      8'h00
`define HFP_ADDR_OFS      8'h04
`define HFP_WDATA_OFS     8'h08
`define HFP_CMD_OFS       8'h0C
`define HFP_STATUS_OFS    8'h10
`define HFP_RDATA_OFS     8'h14

// Control register fields
`define HFP_CTRL_BYTE     0
`define HFP_CTRL_PDOWN    1
`define HFP_CTRL_RP_HV    2
`define HFP_CTRL_WP_HIGH  3
`define HFP_CTRL_SIG_HV   4
`define HFP_CTRL_W        5
`define HFP_CTRL_RST      5'h00

// Command register fields
`define HFP_CMD_READ      0
`define HFP_CMD_WRITE     1

// Status register fields
`define HFP_ST_BUSY       0
`define HFP_ST_OUT_OK     1
`define HFP_ST_WAKE_OK    2
`define HFP_ST_REFUSED    3

// Timing, figures in ns and derived cycle counts (least times round up)
`define HFP_CLK_NS        10
`define HFP_RECOVERY_NS   450
`define HFP_WAKE_NS       300
`define HFP_SETUP_NS      10
`define HFP_WE_LOW_NS     50
`define HFP_HOLD_NS       10
`define HFP_ACCESS_NS     100
`define HFP_SYNC_CYC      2
`define HFP_RECOVERY_CYC  ((`HFP_RECOVERY_NS + `HFP_CLK_NS - 1) / `HFP_CLK_NS)
`define HFP_WAKE_CYC      ((`HFP_WAKE_NS + `HFP_CLK_NS - 1) / `HFP_CLK_NS)
`define HFP_SETUP_CYC     ((`HFP_SETUP_NS + `HFP_CLK_NS - 1) / `HFP_CLK_NS)
`define HFP_WE_LOW_CYC    ((`HFP_WE_LOW_NS + `HFP_CLK_NS - 1) / `HFP_CLK_NS)
`define HFP_HOLD_CYC      ((`HFP_HOLD_NS + `HFP_CLK_NS - 1) / `HFP_CLK_NS)
`define HFP_ACCESS_CYC    (((`HFP_ACCESS_NS + `HFP_CLK_NS - 1) / `HFP_CLK_NS) + `HFP_SYNC_CYC)

`endif

// ===== rtl/hfp_pkg.sv
// Types shared by the boot-block flash host port.
// Assumes nothing beyond a SystemVerilog tool.
package hfp_pkg;
  // Sequencer states of the pin engine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD
  } hfp_state_e;
  typedef logic [15:0] hfp_data_t;   // Flash data bus
  typedef logic [18:0] hfp_addr_t;   // Flash address pins
  typedef logic [15:0] hfp_count_t;  // Timer count
endpackage

// ===== rtl/hfp_timer.sv
// Down counter that times each strobe phase of the pin engine.
// Assumes the loader gives the phase length minus one.
`timescale 1ns/1ps
`default_nettype none
module hfp_timer (
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_load,
  input  wire hfp_pkg::hfp_count_t i_value,
  output logic                   o_done
);
  import hfp_pkg::*;

  hfp_count_t cnt_q;  // Remaining cycles

  // Load wins over counting so a phase starts cleanly
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cnt_q <= 16'h0000;
    end else if (i_load) begin
      cnt_q <= i_value;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // Done once the count has run out. It must not look at the load: the engine
  // loads the next phase from this very flag, and that would close a loop.
  assign o_done = (cnt_q == 16'h0000);
endmodule // hfp_timer
`default_nettype wire

// ===== rtl/hfp_sync.sv
// Two-flop synchroniser for the data pins read back from the flash.
// Assumes the flash data is stable while the output enable is held low.
`timescale 1ns/1ps
`default_nettype none
module hfp_sync (
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  input  wire hfp_pkg::hfp_data_t i_async,
  output hfp_pkg::hfp_data_t     o_sync
);
  import hfp_pkg::*;

  hfp_data_t meta_q;  // First stage, read only by the second
  hfp_data_t sync_q;  // Second stage

  // Plain two-stage capture
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // hfp_sync
`default_nettype wire

// ===== bench/hfp_flash_model.sv
// Pin-level model of a boot-block flash: small array, program, progress flags, identifiers.
// Assumes the bench resolves the shared data wire and feeds it back on i_dq.
`timescale 1ns/1ps
`default_nettype none
module hfp_flash_model #(
  parameter logic [15:0] MFR_ID  = 16'h00A5,  // Arbitrary value
  parameter logic [15:0] DEV_ID  = 16'h005A,  // Arbitrary value
  parameter logic [15:0] PGM_CMD = 16'h0040,  // Program setup code
  parameter logic [15:0] RD_CMD  = 16'h00FF,  // Back to read array
  parameter logic        SUPPLY_OK = 1'b1     // Program supply above its lockout level
) (
  input  wire logic               i_ce_n,
  input  wire logic               i_oe_n,
  input  wire logic               i_we_n,
  input  wire logic               i_rp_n,
  input  wire logic               i_rp_hv,
  input  wire logic               i_wp_n,
  input  wire logic               i_byte_n,
  input  wire logic               i_a9_hv,
  input  wire hfp_pkg::hfp_addr_t i_addr,
  input  wire hfp_pkg::hfp_data_t i_dq,
  output hfp_pkg::hfp_data_t      o_dq,
  output hfp_pkg::hfp_data_t      o_dq_en
);
  import hfp_pkg::*;
  hfp_data_t mem_q [0:255];  // Only eight word address bits kept, to stay small
  hfp_data_t word;           // Value chosen for the wire
  logic      pgm_q;          // Next write is array data
  logic      stat_mode_q;    // Reads return progress flags
  logic      fail_q;         // Program refused: boot block locked or supply low
  logic      boot;           // Top quarter stands for the boot block
  assign boot = (i_addr[7:6] == 2'b11);
  initial for (int i = 0; i < 256; i++) mem_q[i] = 16'hFFFF;
  // Writes land on the rising write strobe; reset pin low clears the mode and fail flags, not the array
  always @(posedge i_we_n or negedge i_rp_n) begin
    if (!i_rp_n) begin
      pgm_q <= 1'b0;
      stat_mode_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (!i_ce_n) begin
      if (pgm_q) begin  // Sequencer runs on its own
        pgm_q <= 1'b0;
        stat_mode_q <= 1'b1;
        if (!SUPPLY_OK || (boot && !i_wp_n && !i_rp_hv)) fail_q <= 1'b1;
        else mem_q[i_addr[7:0]] <= mem_q[i_addr[7:0]] & i_dq;  // One location only
      end else if (i_dq === PGM_CMD) begin
        pgm_q <= 1'b1;
        fail_q <= 1'b0;
      end else if (i_dq === RD_CMD) stat_mode_q <= 1'b0;
    end
  end
  // Drive identifiers, flags or array data only in an enabled read
  always_comb begin
    if (i_a9_hv) word = i_addr[0] ? DEV_ID : MFR_ID;
    else if (stat_mode_q) word = {8'h00, 1'b1, 2'b00, fail_q, 4'h0};  // Ready and fail
    else word = mem_q[i_addr[7:0]];
    if (!i_byte_n && !i_a9_hv && !stat_mode_q && i_dq[15]) word = {8'h00, word[15:8]};
    o_dq = i_byte_n ? word : {8'h00, word[7:0]};  // Byte signature keeps low byte
    o_dq_en = (!i_ce_n && !i_oe_n && i_rp_n) ? (i_byte_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
  end
endmodule  // hfp_flash_model
`default_nettype wire

// ===== bench/hfp_host_tb_top.sv
// Bench for the flash host port: AHB-Lite master tasks, flash model, expected array.
// Assumes the data wire is resolved here; a released line shows the inverse of its last value.
`include "hfp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hfp_host_tb_top;
  import hfp_pkg::*;
  localparam logic [15:0] MFR = 16'h00A5;  // Arbitrary value
  localparam logic [15:0] DEV = 16'h005A;  // Arbitrary value
  localparam logic [15:0] PGM = 16'h0040;
  localparam logic [15:0] RDC = 16'h00FF;
  logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
  logic [1:0]  i_htrans = 2'b00;
  logic        i_hready, o_hreadyout, o_hresp;
  logic        o_ce_n, o_oe_n, o_we_n, o_rp_n, o_rp_hv, o_wp_n, o_byte_n, o_a9_hv;
  hfp_addr_t   o_addr;
  hfp_data_t   o_dq_o, o_dq_oe, dq_w, dq_last_q, fl_o, fl_en;
  logic [15:0] exp_q [int];     // Expected array contents
  logic [15:0] seed_q = 16'h0050;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  assign i_hready = o_hreadyout;
  always #5 i_sys_clk = ~i_sys_clk;
  // Wire level from both drivers; nobody driving gives a changing pattern
  always_comb for (int b = 0; b < 16; b++)
    dq_w[b] = o_dq_oe[b] ? o_dq_o[b] : (fl_en[b] ? fl_o[b] : ~dq_last_q[b]);
  // Known start during reset, so a released line really toggles instead of staying unknown
  always_ff @(posedge i_sys_clk) dq_last_q <= i_resetn ? dq_w : 16'h0000;
  hfp_host u_hfp_host (.i_sys_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'b010), .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .o_ce_n,
    .o_oe_n, .o_we_n, .o_rp_n, .o_rp_hv, .o_wp_n, .o_byte_n, .o_a9_hv, .o_addr, .o_dq_o,
    .o_dq_oe, .i_dq_i(dq_w));
  hfp_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PGM_CMD(PGM), .RD_CMD(RDC)) u_hfp_flash_model (
    .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_rp_n(o_rp_n), .i_rp_hv(o_rp_hv),
    .i_wp_n(o_wp_n), .i_byte_n(o_byte_n), .i_a9_hv(o_a9_hv), .i_addr(o_addr), .i_dq(dq_w),
    .o_dq(fl_o), .o_dq_en(fl_en));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ex(input int a);
    return exp_q.exists(a) ? exp_q[a] : 16'hFFFF;  // Never programmed reads erased
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single transfer; every wait ends on hready sampled high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= {24'h0, a};
    i_hwrite <= wr;
    do @(posedge i_sys_clk); while (i_hready !== 1'b1);
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    do @(posedge i_sys_clk); while (i_hready !== 1'b1);
    rd = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  // Poll status until the masked bits match, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    int k;
    for (k = 0; k < 200; k++) begin
      rd(`HFP_STATUS_OFS, s);
      if ((s & m) === v) break;
    end
    if (k == 200) chk("status poll", v, s & m);
  endtask
  // One flash cycle: address, data, command, wait for idle, fetch read data
  task automatic fop(input logic [19:0] a, input logic [15:0] d, input logic [1:0] c,
                     output logic [31:0] r);
    wr(`HFP_ADDR_OFS, {12'h0, a});
    wr(`HFP_WDATA_OFS, {16'h0, d});
    wr(`HFP_CMD_OFS, {30'h0, c});
    poll(32'h1, 32'h0);
    rd(`HFP_RDATA_OFS, r);
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] r, ctl;
    logic [7:0]  a;
    logic [15:0] s;
    repeat (16) @(posedge i_sys_clk);
    chk("rp_n in reset", 32'h0, {31'h0, o_rp_n});
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    wr(`HFP_CMD_OFS, 32'h1);
    rd(`HFP_STATUS_OFS, r);
    chk("early command", 32'h8, r & 32'h8);
    rd(`HFP_CTRL_OFS, r);
    chk("ctrl reset", 32'h0, r);
    poll(32'h6, 32'h6);
    // Program one word per area; boot area locked, unlocked by high voltage or lock pin
    for (int i = 0; i < 9; i++) begin
      seed_q = lfsr(seed_q);
      a = {(i > 7) ? 3'd7 : i[2:0], seed_q[4:0]};
      ctl = (i == 6) ? 32'h4 : ((i == 8) ? 32'h8 : 32'h0);
      wr(`HFP_CTRL_OFS, ctl);
      fop({12'h0, a}, PGM, 2'b10, r);
      fop({12'h0, a}, seed_q, 2'b10, r);
      fop({12'h0, a}, 16'h0, 2'b01, r);
      chk("flags", (i == 7) ? 32'h90 : 32'h80, r);
      if (i != 7) exp_q[a] = seed_q;
      if (i != 3) fop(20'h0, RDC, 2'b10, r);
      else begin
        wr(`HFP_CTRL_OFS, 32'h2);
        wr(`HFP_CTRL_OFS, 32'h0);
        poll(32'h6, 32'h6);
      end
      fop({12'h0, a}, 16'h0, 2'b01, r);
      chk("array", {16'h0, ex(a)}, r);
      fop({12'h0, a ^ 8'h01}, 16'h0, 2'b01, r);
      chk("neighbour", {16'h0, ex(a ^ 8'h01)}, r);
    end
    // Byte width set while the reset pin is low
    wr(`HFP_CTRL_OFS, 32'h3);
    wr(`HFP_CTRL_OFS, 32'h1);
    poll(32'h6, 32'h6);
    foreach (exp_q[k]) begin
      fop({11'h0, k[7:0], 1'b1}, 16'h0, 2'b01, r);
      chk("byte high", {24'h0, exp_q[k][15:8]}, r);
      fop({11'h0, k[7:0], 1'b0}, 16'h0, 2'b01, r);
      chk("byte low", {24'h0, exp_q[k][7:0]}, r);
    end
    // Identifiers in byte then word width; low address pin set but ignored
    wr(`HFP_CTRL_OFS, 32'h11);
    for (int m = 0; m < 4; m++) begin
      if (m == 2) begin
        wr(`HFP_CTRL_OFS, 32'h12);
        wr(`HFP_CTRL_OFS, 32'h10);
        poll(32'h6, 32'h6);
      end
      s = m[0] ? DEV : MFR;
      fop((m < 2) ? {18'h0, m[0], 1'b1} : {19'h0, m[0]}, 16'h0, 2'b01, r);
      chk("signature", (m < 2) ? {24'h0, s[7:0]} : {16'h0, s}, r);
    end
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, r);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, o_hresp});
    report_and_stop();
  end
endmodule  // hfp_host_tb_top
`default_nettype wire
